// >>> hub_strap_pkg.sv
package hub_strap_pkg;

	// ------------------------------------------------------------
	// strap vector layout
	// ------------------------------------------------------------
	localparam int STRAP_W          = 2;
	localparam int STRAP_SERIAL_BIT = 0;
	localparam int STRAP_PWR_BIT    = 1;

	// ------------------------------------------------------------
	// ports and reset values
	// ------------------------------------------------------------
	localparam int PORT_COUNT = 4;
	localparam int PORT4_IDX  = 3;

	localparam logic [STRAP_W-1:0] STRAP_RST     = 2'h0;
	localparam logic               STRAP_VLD_RST = 1'h0;
	localparam logic               PIN_OE_RST    = 1'h0;
	localparam logic               PIN_LVL_RST   = 1'h1;
	localparam logic               SUSP_RST      = 1'h0;
	localparam logic               RST_SYNC_RST  = 1'h0;

	// open-drain pins only ever pull low
	localparam logic OD_DRIVE_LVL = 1'h0;

	// the serial-mode strap value that picks the eeprom master role
	localparam logic SERIAL_I2C = 1'h1;
	// the power strap value that turns power switching on
	localparam logic PWR_SWITCH_ON = 1'h0;

endpackage

// >>> strap_if.sv
interface strap_if #(
	parameter int W = hub_strap_pkg::STRAP_W
);
	logic [W-1:0] raw;
	logic [W-1:0] value;
	logic         valid;

	modport latch (
		input  raw,
		output value,
		output valid
	);

	modport user (
		output raw,
		input  value,
		input  valid
	);
endinterface

// >>> strap_latch.sv
module strap_latch #(
	parameter int W = hub_strap_pkg::STRAP_W
) (
	// clock and synchronised reset
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	// strap values
	strap_if.latch    straps
);

	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;
	logic         valid_r;
	logic         valid_nxt;

	// ------------------------------------------------------------
	// capture once on the first enabled cycle after reset release
	// ------------------------------------------------------------
	always_comb begin
		valid_nxt = 1'b1;
		value_nxt = valid_r ? value_r : straps.raw;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			value_r <= W'(hub_strap_pkg::STRAP_RST);
			valid_r <= hub_strap_pkg::STRAP_VLD_RST;
		end else if (ce_i) begin
			value_r <= value_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign straps.value = value_r;
	assign straps.valid = valid_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// the release edge itself still finds the flops in reset, so it must not start a check
	property p_strap_capture;
		@(posedge clock_i) disable iff (!rst_n_i)
		(rst_n_i && ce_i && !valid_r) |=> (valid_r && value_r == $past(straps.raw));
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap not captured at release");

	property p_strap_hold;
		@(posedge clock_i) disable iff (!rst_n_i)
		valid_r |=> (valid_r && $stable(value_r));
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("latched strap changed");

endmodule

// >>> hub_strap_and_pin_function.sv
// What this block does
// - a low port-4 over-current input means an over-current event on port 4, a high level means none unless ganged mode sees a low on another port.
// - the serial-mode strap is sampled at reset release, 1 picking i2c and 0 picking smbus.
// - with the strap at 1 the scl and sda pins serve the i2c eeprom master.
// - with the strap at 0 the scl and sda pins serve the smbus slave.
// - after reset, only while status output is enabled, the strap pin shows upstream suspend, 1 meaning suspended.
// - the power strap is sampled at reset release, 0 enabling power switching and over-current monitoring.
// - a power strap of 1 disables power switching and ignores the over-current inputs.
module hub_strap_and_pin_function #(
	parameter int PORTS = hub_strap_pkg::PORT_COUNT
) (
	// clock, reset, enable
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	input  wire logic             ce_i,
	// serial-mode strap / suspend status pin
	input  wire logic             serial_mode_select_i,
	output logic                  serial_mode_select_o,
	output logic                  serial_mode_select_oe_o,
	// power switching strap pin
	input  wire logic             power_switching_disable_strap_i,
	// over-current pins, port 4 and ports 1..3
	input  wire logic             port4_overcurrent_n_i,
	input  wire logic [PORTS-2:0] port_overcurrent_n_i,
	// serial bus pins
	input  wire logic             scl_i,
	output logic                  scl_o,
	output logic                  scl_oe_o,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	// eeprom master engine side
	input  wire logic             mst_scl_pull_i,
	input  wire logic             mst_sda_pull_i,
	output logic                  mst_scl_o,
	output logic                  mst_sda_o,
	// smbus slave engine side
	input  wire logic             slv_scl_pull_i,
	input  wire logic             slv_sda_pull_i,
	output logic                  slv_scl_o,
	output logic                  slv_sda_o,
	// hub core control and status
	input  wire logic             status_output_enable_i,
	input  wire logic             ss_suspend_i,
	input  wire logic             ganged_mode_i,
	input  wire logic [PORTS-1:0] pwrctl_req_i,
	output logic [PORTS-1:0]      pwrctl_o,
	output logic [PORTS-1:0]      overcurrent_o,
	output logic                  i2c_mode_o,
	output logic                  smbus_mode_o,
	output logic                  power_switching_en_o,
	output logic                  straps_valid_o
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_r <= hub_strap_pkg::RST_SYNC_RST;
			rst_n_r    <= hub_strap_pkg::RST_SYNC_RST;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	strap_if #(.W(hub_strap_pkg::STRAP_W)) straps ();

	always_comb begin
		straps.raw                                  = '0;
		straps.raw[hub_strap_pkg::STRAP_SERIAL_BIT] = serial_mode_select_i;
		straps.raw[hub_strap_pkg::STRAP_PWR_BIT]    = power_switching_disable_strap_i;
	end

	strap_latch #(.W(hub_strap_pkg::STRAP_W)) u_strap_latch (
		.clock_i (clock_i),
		.rst_n_i (rst_n_r),
		.ce_i    (ce_i),
		.straps  (straps)
	);

	logic vld;
	logic i2c_mode;
	logic smbus_mode;
	logic pwr_en;

	assign vld        = straps.valid;
	assign i2c_mode   = vld && straps.value[hub_strap_pkg::STRAP_SERIAL_BIT] == hub_strap_pkg::SERIAL_I2C;
	assign smbus_mode = vld && straps.value[hub_strap_pkg::STRAP_SERIAL_BIT] != hub_strap_pkg::SERIAL_I2C;
	assign pwr_en     = vld && straps.value[hub_strap_pkg::STRAP_PWR_BIT] == hub_strap_pkg::PWR_SWITCH_ON;

	assign i2c_mode_o           = i2c_mode;
	assign smbus_mode_o         = smbus_mode;
	assign power_switching_en_o = pwr_en;
	assign straps_valid_o       = vld;

	// ------------------------------------------------------------
	// serial pin routing
	// ------------------------------------------------------------
	// pins stay released until the role is known, so neither engine
	// can glitch the bus while the strap is still being sampled
	logic scl_oe_r;
	logic scl_oe_nxt;
	logic sda_oe_r;
	logic sda_oe_nxt;
	logic mst_scl_r;
	logic mst_scl_nxt;
	logic mst_sda_r;
	logic mst_sda_nxt;
	logic slv_scl_r;
	logic slv_scl_nxt;
	logic slv_sda_r;
	logic slv_sda_nxt;

	always_comb begin
		scl_oe_nxt  = 1'b0;
		sda_oe_nxt  = 1'b0;
		mst_scl_nxt = hub_strap_pkg::PIN_LVL_RST;
		mst_sda_nxt = hub_strap_pkg::PIN_LVL_RST;
		slv_scl_nxt = hub_strap_pkg::PIN_LVL_RST;
		slv_sda_nxt = hub_strap_pkg::PIN_LVL_RST;
		if (i2c_mode) begin
			scl_oe_nxt  = mst_scl_pull_i;
			sda_oe_nxt  = mst_sda_pull_i;
			mst_scl_nxt = scl_i;
			mst_sda_nxt = sda_i;
		end else if (smbus_mode) begin
			scl_oe_nxt  = slv_scl_pull_i;
			sda_oe_nxt  = slv_sda_pull_i;
			slv_scl_nxt = scl_i;
			slv_sda_nxt = sda_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			scl_oe_r  <= hub_strap_pkg::PIN_OE_RST;
			sda_oe_r  <= hub_strap_pkg::PIN_OE_RST;
			mst_scl_r <= hub_strap_pkg::PIN_LVL_RST;
			mst_sda_r <= hub_strap_pkg::PIN_LVL_RST;
			slv_scl_r <= hub_strap_pkg::PIN_LVL_RST;
			slv_sda_r <= hub_strap_pkg::PIN_LVL_RST;
		end else if (ce_i) begin
			scl_oe_r  <= scl_oe_nxt;
			sda_oe_r  <= sda_oe_nxt;
			mst_scl_r <= mst_scl_nxt;
			mst_sda_r <= mst_sda_nxt;
			slv_scl_r <= slv_scl_nxt;
			slv_sda_r <= slv_sda_nxt;
		end
	end

	assign scl_o     = hub_strap_pkg::OD_DRIVE_LVL;
	assign sda_o     = hub_strap_pkg::OD_DRIVE_LVL;
	assign scl_oe_o  = scl_oe_r;
	assign sda_oe_o  = sda_oe_r;
	assign mst_scl_o = mst_scl_r;
	assign mst_sda_o = mst_sda_r;
	assign slv_scl_o = slv_scl_r;
	assign slv_sda_o = slv_sda_r;

	// ------------------------------------------------------------
	// suspend status on the strap pin
	// ------------------------------------------------------------
	logic susp_oe_r;
	logic susp_oe_nxt;
	logic susp_r;
	logic susp_nxt;

	always_comb begin
		susp_oe_nxt = vld && status_output_enable_i;
		susp_nxt    = ss_suspend_i;
	end

	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			susp_oe_r <= hub_strap_pkg::PIN_OE_RST;
			susp_r    <= hub_strap_pkg::SUSP_RST;
		end else if (ce_i) begin
			susp_oe_r <= susp_oe_nxt;
			susp_r    <= susp_nxt;
		end
	end

	assign serial_mode_select_oe_o = susp_oe_r;
	assign serial_mode_select_o    = susp_r;

	// ------------------------------------------------------------
	// over-current and power control
	// ------------------------------------------------------------
	logic [PORTS-1:0] oc_r;
	logic [PORTS-1:0] oc_nxt;
	logic [PORTS-1:0] pwr_r;
	logic [PORTS-1:0] pwr_nxt;
	logic [PORTS-1:0] oc_pin_n;
	logic             oc_any;

	// unused inputs float high through their pull-ups, so one shared
	// fault wire on any input is enough in ganged mode
	assign oc_pin_n = {port4_overcurrent_n_i, port_overcurrent_n_i};
	assign oc_any   = ~&oc_pin_n;

	always_comb begin
		oc_nxt  = '0;
		pwr_nxt = '0;
		if (pwr_en) begin
			oc_nxt  = ganged_mode_i ? {PORTS{oc_any}} : ~oc_pin_n;
			pwr_nxt = pwrctl_req_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			oc_r  <= '0;
			pwr_r <= '0;
		end else if (ce_i) begin
			oc_r  <= oc_nxt;
			pwr_r <= pwr_nxt;
		end
	end

	assign overcurrent_o = oc_r;
	assign pwrctl_o      = pwr_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_oc_port4;
		@(posedge clock_i) disable iff (!rst_n_r)
		(ce_i && pwr_en) |=> (oc_r[hub_strap_pkg::PORT4_IDX] == !$past(port4_overcurrent_n_i)
			|| $past(ganged_mode_i));
	endproperty
	a_oc_port4: assert property (p_oc_port4) else $error("port 4 over-current wrong");

	property p_i2c_route;
		@(posedge clock_i) disable iff (!rst_n_r)
		(ce_i && i2c_mode) |=> (sda_oe_o == $past(mst_sda_pull_i) && mst_scl_o == $past(scl_i));
	endproperty
	a_i2c_route: assert property (p_i2c_route) else $error("i2c pins not routed to master");

	property p_smbus_route;
		@(posedge clock_i) disable iff (!rst_n_r)
		(ce_i && smbus_mode) |=> (scl_oe_o == $past(slv_scl_pull_i) && slv_sda_o == $past(sda_i));
	endproperty
	a_smbus_route: assert property (p_smbus_route) else $error("smbus pins not routed to slave");

	property p_susp_out;
		@(posedge clock_i) disable iff (!rst_n_r)
		(rst_n_r && ce_i) |=> (serial_mode_select_oe_o == ($past(vld) && $past(status_output_enable_i))
			&& serial_mode_select_o == $past(ss_suspend_i));
	endproperty
	a_susp_out: assert property (p_susp_out) else $error("suspend status output wrong");

	property p_pwr_on;
		@(posedge clock_i) disable iff (!rst_n_r)
		(ce_i && pwr_en) |=> (pwrctl_o == $past(pwrctl_req_i));
	endproperty
	a_pwr_on: assert property (p_pwr_on) else $error("power control not passed");

	property p_pwr_off;
		@(posedge clock_i) disable iff (!rst_n_r)
		(vld && !pwr_en) |=> (pwrctl_o == '0 && overcurrent_o == '0)[*2];
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power switching not disabled");

	property p_mode_stable;
		@(posedge clock_i) disable iff (!rst_n_r)
		vld |=> ($stable(i2c_mode_o) && $stable(power_switching_en_o) && (i2c_mode_o != smbus_mode_o));
	endproperty
	a_mode_stable: assert property (p_mode_stable) else $error("strap mode changed after release");

endmodule

// >>> serial_bus_peer.sv
// ------------------------------------------------------------
// eeprom or smbus host on the two serial pins
// ------------------------------------------------------------
module serial_bus_peer (
	// hub side open-drain enables
	input  wire logic scl_oe_i,
	input  wire logic sda_oe_i,
	// peer wants the line low
	input  wire logic scl_pull_i,
	input  wire logic sda_pull_i,
	// resolved wire levels
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// board pull-ups: a line nobody pulls reads high
	assign scl_o = ~(scl_oe_i | scl_pull_i);
	assign sda_o = ~(sda_oe_i | sda_pull_i);
endmodule

// >>> hub_strap_and_pin_function_tb.sv
module hub_strap_and_pin_function_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic       clock_i = 1'h0;
	logic       nrst_i  = 1'h0;
	logic       ser_strap = 1'h1, pwr_strap = 1'h0, oc4_n = 1'h1, sts_en = 1'h0, susp = 1'h0;
	logic       ganged = 1'h0, peer_scl = 1'h0, peer_sda = 1'h0, ce = 1'h1;
	logic       mst_scl_pull = 1'h0, mst_sda_pull = 1'h0, slv_scl_pull = 1'h0, slv_sda_pull = 1'h0;
	logic [2:0] oc_n    = 3'h7;
	logic [3:0] pwr_req = 4'h0;
	logic       ser_o, ser_oe, ser_pin, scl_lvl, sda_lvl, scl_oe, sda_oe;
	logic       mst_scl, mst_sda, slv_scl, slv_sda, i2c, smb, pwren, vld, scl_do, sda_do;
	logic [3:0] pwrctl, oc;
	int         error_cnt = 0;
	int         n_checks  = 0;

	always #5 clock_i = ~clock_i;

	// strap pin is two-way: the hub's drive wins over the board strap
	assign ser_pin = ser_oe ? ser_o : ser_strap;

	hub_strap_and_pin_function u_hub_strap_and_pin_function (
		.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
		.serial_mode_select_i(ser_pin), .serial_mode_select_o(ser_o), .serial_mode_select_oe_o(ser_oe),
		.power_switching_disable_strap_i(pwr_strap),
		.port4_overcurrent_n_i(oc4_n), .port_overcurrent_n_i(oc_n),
		.scl_i(scl_lvl), .scl_o(scl_do), .scl_oe_o(scl_oe), .sda_i(sda_lvl), .sda_o(sda_do), .sda_oe_o(sda_oe),
		.mst_scl_pull_i(mst_scl_pull), .mst_sda_pull_i(mst_sda_pull), .mst_scl_o(mst_scl), .mst_sda_o(mst_sda),
		.slv_scl_pull_i(slv_scl_pull), .slv_sda_pull_i(slv_sda_pull), .slv_scl_o(slv_scl), .slv_sda_o(slv_sda),
		.status_output_enable_i(sts_en), .ss_suspend_i(susp), .ganged_mode_i(ganged),
		.pwrctl_req_i(pwr_req), .pwrctl_o(pwrctl), .overcurrent_o(oc),
		.i2c_mode_o(i2c), .smbus_mode_o(smb), .power_switching_en_o(pwren), .straps_valid_o(vld)
	);

	serial_bus_peer u_serial_bus_peer (
		.scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_pull_i(peer_scl), .sda_pull_i(peer_sda),
		.scl_o(scl_lvl), .sda_o(sda_lvl)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [3:0] exp, input logic [3:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic print_verdict;
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic settle;
		@(posedge clock_i);
		@(negedge clock_i);
	endtask

	// reset with given straps, then move the strap pins to show they are ignored
	task automatic boot(input logic s, input logic p);
		int i;
		@(posedge clock_i);
		nrst_i    <= 1'h0;
		ser_strap <= s;
		pwr_strap <= p;
		repeat (12) @(posedge clock_i);
		chk(4'h0, {i2c, smb, pwren, vld});
		chk(4'hf, {mst_scl, mst_sda, slv_scl, slv_sda});
		nrst_i <= 1'h1;
		for (i = 0; i < 8 && vld !== 1'h1; i++)
			@(negedge clock_i);
		if (vld !== 1'h1) begin
			error_cnt++;
			print_verdict();
		end
		@(posedge clock_i);
		ser_strap <= ~s;
		pwr_strap <= ~p;
		settle();
	endtask

	initial begin
		repeat (5000) @(posedge clock_i);
		error_cnt++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		boot(1'h1, 1'h0);
		chk(4'hb, {i2c, smb, pwren, vld});
		@(posedge clock_i);
		mst_sda_pull <= 1'h1;
		slv_scl_pull <= 1'h1;
		peer_scl     <= 1'h1;
		settle();
		settle();
		chk(4'h4, {scl_oe, sda_oe, mst_scl, mst_sda});
		chk(4'h3, {2'h0, slv_scl, slv_sda});
		chk(4'h0, {2'h0, scl_do, sda_do});
		@(posedge clock_i);
		mst_sda_pull <= 1'h0;
		slv_scl_pull <= 1'h0;
		peer_scl     <= 1'h0;
		oc4_n        <= 1'h0;
		pwr_req      <= 4'ha;
		settle();
		chk(4'h8, oc);
		chk(4'ha, pwrctl);
		@(posedge clock_i);
		ganged <= 1'h1;
		settle();
		chk(4'hf, oc);
		@(posedge clock_i);
		ganged <= 1'h0;
		oc4_n  <= 1'h1;
		oc_n   <= 3'h6;
		settle();
		chk(4'h1, oc);
		@(posedge clock_i);
		sts_en <= 1'h1;
		susp   <= 1'h1;
		settle();
		chk(4'h3, {2'h0, ser_oe, ser_o});
		chk(4'hb, {i2c, smb, pwren, vld});
		// clock enable low: the status pin must keep its last value
		@(posedge clock_i);
		ce   <= 1'h0;
		susp <= 1'h0;
		settle();
		chk(4'h3, {2'h0, ser_oe, ser_o});
		@(posedge clock_i);
		ce <= 1'h1;
		@(posedge clock_i);
		susp <= 1'h0;
		settle();
		chk(4'h2, {2'h0, ser_oe, ser_o});
		@(posedge clock_i);
		sts_en <= 1'h0;
		oc_n   <= 3'h7;
		settle();
		chk(4'h0, {2'h0, ser_oe, ser_o});

		boot(1'h0, 1'h1);
		chk(4'h5, {i2c, smb, pwren, vld});
		@(posedge clock_i);
		slv_scl_pull <= 1'h1;
		mst_sda_pull <= 1'h1;
		peer_sda     <= 1'h1;
		oc4_n        <= 1'h0;
		ganged       <= 1'h1;
		pwr_req      <= 4'hf;
		sts_en       <= 1'h1;
		susp         <= 1'h1;
		settle();
		settle();
		chk(4'h8, {scl_oe, sda_oe, slv_scl, slv_sda});
		chk(4'h3, {2'h0, mst_scl, mst_sda});
		chk(4'h0, oc);
		chk(4'h0, pwrctl);
		chk(4'h3, {2'h0, ser_oe, ser_o});
		print_verdict();
	end
endmodule
